/* File: rtl/cpm_meter_agc.sv */
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module cpm_meter_agc
   import cpm_pkg::*;
(
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_srst,
   // AHB-Lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // Filtered samples and sync sources
   input  wire cpm_smp_type i_smp,
   input  wire logic [7:0]  i_sync_src,
   // Results
   output logic             o_pwr_ready,
   output logic             o_pwr_path_b,
   output cpm_smp_type      o_agc
);
   // --------------------
   // Declarations
   // --------------------
   logic [31:0]             ctrl_q, pmcfg_q, step_q, lims_q;
   logic [31:0]             gaina_q, gainb_q, amm_q, rd_d;
   logic                    wr_pend_q, clr_q, addr_ok, nb, frz, sel_b;
   logic [7:0]              wr_addr_q;
   cpm_pm_state_type        pm_st_q;
   logic                    sync_prev_q, sync_sel, sync_hit, adv_a;
   logic                    ivl_end, restart;
   logic [8:0]              dly_cnt_q, dly_last;
   logic [18:0]             ivl_cnt_q, ivl_last;
   logic [17:0]             int_last;
   logic [1:0]              latch;
   logic [ACC_W-1:0]        res [2];
   logic signed [SQ_W-1:0]  ie, qe;
   logic [SQ_W-1:0]         sq;
   logic signed [ADJ_W-1:0] adj_q [2];
   logic signed [ADJ_W-1:0] adj_cur, eff_raw, eff, delta, amax_e, amin_e;
   logic [GAIN_W-1:0]       gbase;
   logic [MAG_W-1:0]        mag_i, mag_q, mag;
   logic                    is_zero, is_max, up;
   logic [3:0]              zcnt_q, scnt_q, dcode;
   logic [SMP_W-1:0]        out_i, out_q;

   // --------------------
   // Functions
   // --------------------
   // Scale, saturate, round and trim one sample
   function automatic logic [SMP_W-1:0] agc_shape(input logic signed [SMP_W-1:0] x,
      input logic signed [ADJ_W-1:0] g, input logic [3:0] md, input logic rnd_dis);
      logic signed [44:0] prod;
      logic signed [32:0] scl;
      logic signed [18:0] r;
      logic [3:0]         m;
      logic [SMP_W-1:0]   s;
      prod = 45'(x) * 45'(g);
      scl  = prod[44:FRAC_W];
      if (scl > 33'sh0_0001_FFFF)
         s = 18'h1_FFFF;
      else if (scl < -33'sh0_0002_0000)
         s = 18'h2_0000;
      else
         s = scl[SMP_W-1:0];
      m = (md > 4'(MD_MAX)) ? 4'(MD_MAX) : md;
      if (!rnd_dis && m != 4'h0) begin
         r = 19'(signed'(s)) + (19'sh0_0001 <<< (m - 4'h1));
         s = (r > 19'sh0_1FFFF) ? 18'h1_FFFF : r[SMP_W-1:0];
         s = s & ~((18'h0_0001 << m) - 18'h0_0001);
      end
      return s;
   endfunction

   // Top eight magnitude bits; full-scale negative clips
   function automatic logic [MAG_W-1:0] mag8(input logic [SMP_W-1:0] x);
      logic [SMP_W-1:0] a;
      a = x[17] ? (~x + 18'h0_0001) : x;
      return a[17] ? 8'hFF : a[16:MAG_LSB];
   endfunction

   // --------------------
   // AHB-Lite slave
   // --------------------
   assign addr_ok = i_hsel & i_htrans[1] & i_hready;

   // Address phase capture; write data lands next cycle
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= 8'h00;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         wr_pend_q   <= addr_ok & i_hwrite & (i_hsize == HSIZE_WORD);
         wr_addr_q   <= i_haddr[7:0];
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end

   // Writable registers; clear bit is a one-cycle strobe
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         ctrl_q  <= R_CTRL;
         pmcfg_q <= R_PMCFG;
         step_q  <= R_STEP;
         lims_q  <= R_LIMS;
         gaina_q <= R_GAIN;
         gainb_q <= R_GAIN;
         amm_q   <= R_AMM;
         clr_q   <= 1'b0;
      end else begin
         clr_q <= wr_pend_q & (wr_addr_q == A_CTRL) & i_hwdata[C_CLR];
         if (wr_pend_q) begin
            case (wr_addr_q)
               A_CTRL:  ctrl_q  <= i_hwdata & R_CTRL_MASK;
               A_PMCFG: pmcfg_q <= i_hwdata;
               A_STEP:  step_q  <= i_hwdata;
               A_LIMS:  lims_q  <= {24'h00_0000, i_hwdata[7:0]};
               A_GAINA: gaina_q <= {8'h00, i_hwdata[23:0]};
               A_GAINB: gainb_q <= {8'h00, i_hwdata[23:0]};
               A_AMM:   amm_q   <= i_hwdata;
               default: ;
            endcase
         end
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      case (i_haddr[7:0])
         A_CTRL:  rd_d = ctrl_q & ~(32'h0000_0001 << C_CLR);
         A_PMCFG: rd_d = pmcfg_q;
         A_STEP:  rd_d = step_q;
         A_LIMS:  rd_d = lims_q;
         A_GAINA: rd_d = gaina_q;
         A_GAINB: rd_d = gainb_q;
         A_AMM:   rd_d = amm_q;
         A_STAT:  rd_d = {20'h0_0000, scnt_q, zcnt_q, 2'b00, pm_st_q};
         A_RAL:   rd_d = res[0][31:0];
         A_RAH:   rd_d = {9'h000, res[0][54:32]};
         A_RBL:   rd_d = res[1][31:0];
         A_RBH:   rd_d = {9'h000, res[1][54:32]};
         A_ADJA:  rd_d = {{5{adj_q[0][ADJ_W-1]}}, adj_q[0]};
         A_ADJB:  rd_d = {{5{adj_q[1][ADJ_W-1]}}, adj_q[1]};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // Read data registered so it stands through the data phase
   always_ff @(posedge i_core_clk) begin
      if (i_srst)
         o_hrdata <= 32'h0000_0000;
      else if (addr_ok & ~i_hwrite)
         o_hrdata <= rd_d;
   end

   // --------------------
   // Power meter
   // --------------------
   assign nb       = ctrl_q[C_NB];
   assign sync_sel = i_sync_src[ctrl_q[C_SSEL +: 3]];
   assign sync_hit = sync_sel & ~sync_prev_q & ~ctrl_q[C_SDIS];
   assign adv_a    = i_smp.valid & ~(nb & i_smp.path_b);
   assign dly_last = {1'b0, pmcfg_q[P_DLY +: 8]} + SYNC_FIX;
   assign ivl_last = {1'b0, pmcfg_q[P_IVL +: 8], {IVL_LOG2{1'b1}}};
   assign int_last = {pmcfg_q[P_SQR +: 16], {INT_LOG2{1'b0}}};
   assign ivl_end  = ivl_cnt_q == ivl_last;
   assign restart  = (pm_st_q == PM_RUN) & adv_a & ivl_end & ~sync_hit;
   assign ie       = SQ_W'(i_smp.i);
   assign qe       = SQ_W'(i_smp.q);
   assign sq       = $unsigned(ie * ie + qe * qe);

   // Sequencer: sync, start delay, then interval timing
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         pm_st_q     <= PM_IDLE;
         sync_prev_q <= 1'b0;
         dly_cnt_q   <= 9'h000;
         ivl_cnt_q   <= 19'h0_0000;
      end else begin
         sync_prev_q <= sync_sel;
         if (sync_hit) begin
            pm_st_q   <= PM_DELAY;
            dly_cnt_q <= 9'h000;
            ivl_cnt_q <= 19'h0_0000;
         end else begin
            case (pm_st_q)
               PM_DELAY: begin
                  if (adv_a) begin
                     dly_cnt_q <= dly_cnt_q + 9'h001;
                     if (dly_cnt_q == dly_last)
                        pm_st_q <= PM_RUN;
                  end
               end
               PM_RUN: begin
                  if (adv_a)
                     ivl_cnt_q <= ivl_end ? 19'h0_0000 : ivl_cnt_q + 19'h0_0001;
               end
               default: ;
            endcase
         end
      end
   end

   // One integrator per path; B only runs in multi-path mode
   for (genvar p = 0; p < 2; p++) begin : g_path
      localparam logic PB = 1'(p);
      logic [ACC_W-1:0] acc_q, res_q;
      logic [17:0]      cnt_q;
      logic             done_q, hit;
      assign hit      = i_smp.valid & (nb ? (i_smp.path_b == PB) : ~PB);
      assign latch[p] = (pm_st_q == PM_RUN) & hit & ~done_q & (cnt_q == int_last)
                        & ~sync_hit & ~restart;
      assign res[p]   = res_q;
      // Running sum, cleared by sync, restart or leaving run
      always_ff @(posedge i_core_clk) begin
         if (i_srst || sync_hit || restart || pm_st_q != PM_RUN) begin
            acc_q  <= '0;
            cnt_q  <= 18'h0_0000;
            done_q <= 1'b0;
         end else if (hit & ~done_q) begin
            acc_q  <= acc_q + ACC_W'(sq);
            cnt_q  <= cnt_q + 18'h0_0001;
            done_q <= cnt_q == int_last;
         end
      end
      // Holding register; no read handshake, newest wins
      always_ff @(posedge i_core_clk) begin
         if (i_srst)
            res_q <= '0;
         else if (latch[p])
            res_q <= acc_q + ACC_W'(sq);
      end
   end

   // Ready pulse, one per latched result
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_pwr_ready  <= 1'b0;
         o_pwr_path_b <= 1'b0;
      end else begin
         o_pwr_ready  <= |latch;
         o_pwr_path_b <= latch[1];
      end
   end

   // --------------------
   // Gain control
   // --------------------
   assign sel_b   = nb & i_smp.path_b;
   assign gbase   = sel_b ? gainb_q[23:0] : gaina_q[23:0];
   assign adj_cur = adj_q[sel_b];
   assign eff_raw = signed'({3'b000, gbase}) + adj_cur;
   assign eff     = eff_raw[ADJ_W-1] ? '0 : eff_raw;
   assign out_i   = agc_shape(i_smp.i, eff, step_q[S_MD +: 4], ctrl_q[C_RNDD]);
   assign out_q   = agc_shape(i_smp.q, eff, step_q[S_MD +: 4], ctrl_q[C_RNDD]);
   assign mag_i   = mag8(out_i);
   assign mag_q   = mag8(out_q);
   assign mag     = (mag_i > mag_q) ? mag_i : mag_q;
   assign is_zero = (mag & ~{4'h0, step_q[S_ZMSK +: 4]}) == 8'h00;
   assign is_max  = mag == 8'hFF;
   assign up      = mag <= step_q[S_THR +: 8];
   assign frz     = ctrl_q[C_FRZ] | i_sync_src[ctrl_q[C_FSEL +: 3]];
   assign amax_e  = {{3{amm_q[M_AMAX+15]}}, amm_q[M_AMAX +: 16], 8'h00};
   assign amin_e  = {{3{amm_q[M_AMIN+15]}}, amm_q[M_AMIN +: 16], 8'h00};
   assign delta   = eff >>> (5'(dcode) + D_BASE);

   // Step choice: fast cases override the threshold cases
   always_comb begin
      if (zcnt_q > lims_q[L_ZLIM +: 4])
         dcode = step_q[S_ZRO +: 4];
      else if (scnt_q > lims_q[L_SLIM +: 4])
         dcode = step_q[S_SAT +: 4];
      else if (up)
         dcode = step_q[S_BLW +: 4];
      else
         dcode = step_q[S_ABV +: 4];
   end

   // Adjustment and the zero/saturation trend counters
   always_ff @(posedge i_core_clk) begin
      if (i_srst || clr_q) begin
         adj_q[0] <= '0;
         adj_q[1] <= '0;
         zcnt_q   <= 4'h0;
         scnt_q   <= 4'h0;
      end else if (i_smp.valid) begin
         if (!frz && up && !(adj_cur > amax_e))
            adj_q[sel_b] <= adj_cur + delta;
         else if (!frz && !up && !(adj_cur < amin_e))
            adj_q[sel_b] <= adj_cur - delta;
         if (is_zero && zcnt_q != 4'hF)
            zcnt_q <= zcnt_q + 4'h1;
         else if (!is_zero && zcnt_q != 4'h0)
            zcnt_q <= zcnt_q - 4'h1;
         if (is_max && scnt_q != 4'hF)
            scnt_q <= scnt_q + 4'h1;
         else if (!is_max && scnt_q != 4'h0)
            scnt_q <= scnt_q - 4'h1;
      end
   end

   // Gain stage output, one cycle after input
   always_ff @(posedge i_core_clk) begin
      if (i_srst)
         o_agc <= '0;
      else
         o_agc <= '{valid: i_smp.valid, path_b: i_smp.path_b, i: out_i, q: out_q};
   end

   // --------------------
   // Assertions
   // --------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   property p_rdy;
      latch != 2'b00 |=> o_pwr_ready && (o_pwr_path_b == $past(latch[1]));
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready pulse missing");
   property p_rdy_once;
      o_pwr_ready && !$past(latch[0] && latch[1]) |-> $past(latch) != 2'b00;
   endproperty
   a_rdy_once: assert property (p_rdy_once) else $error("spurious ready");
   property p_sync;
      sync_hit |=> pm_st_q == PM_DELAY && dly_cnt_q == 9'h000 && ivl_cnt_q == 19'h0_0000;
   endproperty
   a_sync: assert property (p_sync) else $error("sync did not zero counters");
   property p_sdis;
      ctrl_q[C_SDIS] && pm_st_q != PM_DELAY |=> $stable(pm_st_q);
   endproperty
   a_sdis: assert property (p_sdis) else $error("disabled sync started meter");
   property p_dly;
      pm_st_q == PM_DELAY && adv_a && dly_cnt_q == dly_last && !sync_hit |=> pm_st_q == PM_RUN;
   endproperty
   a_dly: assert property (p_dly) else $error("integration start wrong");
   property p_len;
      latch[0] |=> g_path[0].done_q && g_path[0].cnt_q == $past(int_last) + 18'h0_0001
                   && g_path[0].res_q == g_path[0].acc_q;
   endproperty
   a_len: assert property (p_len) else $error("integration length wrong");
   property p_restart;
      restart |=> ivl_cnt_q == 19'h0_0000 && g_path[0].cnt_q == 18'h0_0000;
   endproperty
   a_restart: assert property (p_restart) else $error("interval restart failed");
   property p_frz;
      frz && !clr_q |=> $stable(adj_q[0]) && $stable(adj_q[1]);
   endproperty
   a_frz: assert property (p_frz) else $error("adjustment moved while frozen");
   property p_dn;
      i_smp.valid && !frz && !clr_q && !up && !sel_b |=> adj_q[0] <= $past(adj_q[0]);
   endproperty
   a_dn: assert property (p_dn) else $error("gain rose above threshold");
   property p_zcnt;
      i_smp.valid && !clr_q && is_zero && zcnt_q != 4'hF |=> zcnt_q == $past(zcnt_q) + 4'h1;
   endproperty
   a_zcnt: assert property (p_zcnt) else $error("zero counter stuck");
   property p_scnt;
      i_smp.valid && !clr_q && !is_max && scnt_q != 4'h0 |=> scnt_q == $past(scnt_q) - 4'h1;
   endproperty
   a_scnt: assert property (p_scnt) else $error("saturation counter stuck");
endmodule

/* File: rtl/cpm_pkg.sv */
// Behaviour
// - Square 18-bit I and Q after the filter, add, accumulate over integration period.
// - Interval timer advances in 1024-sample units, 1 to 256 units.
// - Integration starts 3 samples plus programmed 8-bit delay (1..256) after sync.
// - At integration end copy 55-bit sum to holding register, flag new result.
// - At interval end restart both counters; each new result overwrites the last.
// - Every accepted sync zeroes all meter counters at once, whatever the state.
// - Wideband mode gives one result; multi-path mode gives separate A and B results.
// - 16-bit count in units of four; power sums over count times four plus one.
// - 3-bit select picks the meter sync; a disable bit blocks it locally.
// - Gain stage multiplies 18-bit sample by 24-bit gain, 12.12 format.
// - Scaled output saturates to full scale, then rounds to 4..18 bits.
// - Magnitude above threshold lowers the gain, otherwise gain rises.
// - Effective gain is base plus adjustment; update adds gain times plus/minus 2^-D.
// - Four 4-bit step codes: below, above, consistently zero, consistently saturated.
// - 4-bit counter rises on zero magnitude, falls otherwise; past limit use zero step.
// - Second counter rises on maximum magnitude, falls otherwise; past limit use saturation step.
// - Magnitude counts as zero when zero after masking its low bits.
// - Nonzero below threshold uses below step; above but unsaturated uses above step.
// - Adjustment stops rising above maximum limit and stops falling below minimum limit.
// - Adaptation holds while freeze bit or selected freeze sync is high.
// - Step code encodes D as code plus 3.
package cpm_pkg;
   // --------------------
   // Widths and counts
   // --------------------
   localparam int SMP_W = 18, ACC_W = 55, SQ_W = 37, GAIN_W = 24;
   localparam int FRAC_W = 12, ADJ_W = 27, MAG_W = 8, MAG_LSB = 9;
   localparam int IVL_LOG2 = 10, INT_LOG2 = 2, MD_MAX = 14;
   localparam logic [8:0] SYNC_FIX = 9'h003;
   localparam logic [4:0] D_BASE   = 5'h03;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // --------------------
   // Register byte offsets
   // --------------------
   localparam logic [7:0] A_CTRL = 8'h00, A_PMCFG = 8'h04, A_STEP = 8'h08;
   localparam logic [7:0] A_LIMS = 8'h0C, A_GAINA = 8'h10, A_GAINB = 8'h14;
   localparam logic [7:0] A_AMM  = 8'h18, A_STAT  = 8'h1C, A_RAL   = 8'h20;
   localparam logic [7:0] A_RAH  = 8'h24, A_RBL   = 8'h28, A_RBH   = 8'h2C;
   localparam logic [7:0] A_ADJA = 8'h30, A_ADJB  = 8'h34;
   // --------------------
   // Field positions
   // --------------------
   localparam int C_NB = 0, C_SDIS = 1, C_SSEL = 2, C_FSEL = 5;
   localparam int C_FRZ = 8, C_RNDD = 9, C_CLR = 10;
   localparam int P_SQR = 0, P_DLY = 16, P_IVL = 24;
   localparam int S_BLW = 0, S_ABV = 4, S_ZRO = 8, S_SAT = 12;
   localparam int S_ZMSK = 16, S_MD = 20, S_THR = 24;
   localparam int L_ZLIM = 0, L_SLIM = 4, M_AMAX = 0, M_AMIN = 16;
   // --------------------
   // Reset values
   // --------------------
   localparam logic [31:0] R_CTRL = 32'h0000_0000, R_CTRL_MASK = 32'h0000_03FF;
   localparam logic [31:0] R_PMCFG = 32'h0400_0000, R_STEP = 32'h4000_2277;
   localparam logic [31:0] R_LIMS = 32'h0000_0088, R_GAIN = 32'h0000_1000;
   localparam logic [31:0] R_AMM = 32'h8000_7FFF;
   // --------------------
   // Types
   // --------------------
   typedef enum logic [1:0] {
      PM_IDLE  = 2'b00,
      PM_DELAY = 2'b01,
      PM_RUN   = 2'b10
   } cpm_pm_state_type;
   typedef struct packed {
      logic                    valid;
      logic                    path_b;
      logic signed [SMP_W-1:0] i;
      logic signed [SMP_W-1:0] q;
   } cpm_smp_type;
endpackage

/* File: testbench/cpm_src_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Upstream filter output, one pair a cycle
// ----------------------------------------
module cpm_src_model
   import cpm_pkg::*;
(
   // Clock and reset
   input  wire logic               i_core_clk,
   input  wire logic               i_srst,
   // Stream shape from the bench
   input  wire logic               i_en,
   input  wire logic               i_alt,
   input  wire logic signed [17:0] i_ia,
   input  wire logic signed [17:0] i_qa,
   input  wire logic signed [17:0] i_ib,
   input  wire logic signed [17:0] i_qb,
   // Filtered samples
   output cpm_smp_type             o_smp
);
   logic pb_d;

   // Alternate paths only in multi-path traffic
   assign pb_d = i_alt ? ~o_smp.path_b : 1'b0;

   // Full-width 18-bit pairs; idle pairs flip so stale data never repeats
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_smp <= '0;
      end else begin
         o_smp.valid  <= i_en;
         o_smp.path_b <= pb_d;
         o_smp.i      <= !i_en ? ~o_smp.i : (pb_d ? i_ib : i_ia);
         o_smp.q      <= !i_en ? ~o_smp.q : (pb_d ? i_qb : i_qa);
      end
   end
endmodule

/* File: testbench/channel_power_meter_and_agc_test.sv */
`timescale 1ns/1ps
module channel_power_meter_and_agc_test
   import cpm_pkg::*;
;
   logic               clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic        [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic        [1:0]  htrans = 2'b00;
   logic        [2:0]  hsize = 3'h0;
   logic               hready, hresp, pwr_ready, pwr_b, en = 1'b0, alt = 1'b0;
   logic        [7:0]  sync_src = 8'h00;
   logic signed [17:0] ia = 18'sd3, qa = 18'sd4, ib = 18'sd1, qb = 18'sd2;
   cpm_smp_type        smp, agc;
   int                 bad_count = 0, n_compared = 0, n;

   always #20 clk = ~clk;

   cpm_src_model src (.i_core_clk(clk), .i_srst(srst), .i_en(en), .i_alt(alt), .i_ia(ia), .i_qa(qa),
                      .i_ib(ib), .i_qb(qb), .o_smp(smp));
   cpm_meter_agc dut (.i_core_clk(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
                      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
                      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_smp(smp),
                      .i_sync_src(sync_src), .o_pwr_ready(pwr_ready), .o_pwr_path_b(pwr_b), .o_agc(agc));

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic print_verdict();
      $display("Counts: compared %0d, mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic miss(input string msg);
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
   endtask

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) miss($sformatf("got %h, expected %h", got, exp));
   endtask

   task automatic chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) miss(msg);
   endtask

   // ----------------------------------------
   // AHB-Lite single word transfers
   // ----------------------------------------
   task automatic wait_hready();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (k >= 50) begin
         miss("bus wait ran out");
         print_verdict();
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      wait_hready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_hready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      cmp32(rd, exp);
      chk(hresp === 1'b0, "bus response not OKAY");
   endtask

   // ----------------------------------------
   // Meter helpers
   // ----------------------------------------
   task automatic sync_pulse(input int b);
      @(posedge clk);
      sync_src[b] <= 1'b1;
      @(posedge clk);
      sync_src[b] <= 1'b0;
   endtask

   // Bounded wait for a latch of the given path, spacing checked against lo..hi
   task automatic wait_ready(input logic want_b, input int lo, input int hi);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(pwr_ready === 1'b1 && pwr_b === want_b) && n < hi + 1);
      chk(n >= lo && n <= hi, $sformatf("ready after %0d cycles", n));
   endtask

   task automatic no_ready(input int cyc);
      repeat (cyc) begin
         @(posedge clk);
         if (pwr_ready !== 1'b0) miss("unexpected ready");
      end
      n_compared++;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] a0, a1;
      logic [23:0] gtab [5];
      logic [3:0]  mtab [5];
      logic [31:0] etab [5];
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      en   <= 1'b1;
      // Reset values, and an unmapped place reading zero
      rdc(A_CTRL, R_CTRL);
      rdc(A_PMCFG, R_PMCFG);
      rdc(A_STEP, R_STEP);
      rdc(A_LIMS, R_LIMS);
      rdc(A_GAINA, R_GAIN);
      rdc(A_AMM, R_AMM);
      rdc(8'hF0, 32'h0000_0000);
      $display("test reset_values done");

      // Wideband: N=1 (5 samples), delay 7, interval 2 kept above N
      wr(A_CTRL, 32'h0000_000C);
      wr(A_PMCFG, 32'h0207_0001);
      sync_pulse(3);
      wait_ready(1'b0, 17, 17);
      @(posedge clk);
      chk(pwr_ready === 1'b0, "ready wider than one cycle");
      rdc(A_RAL, 32'h0000_007D);
      rdc(A_RAH, 32'h0000_0000);
      wait_ready(1'b0, 3067, 3067);
      sync_pulse(0);
      no_ready(40);
      sync_pulse(3);
      wait_ready(1'b0, 17, 17);
      wr(A_CTRL, 32'h0000_000E);
      sync_pulse(3);
      no_ready(40);
      $display("test wideband_meter done");

      // Multi-path: A pairs 25 each, B pairs 5 each
      alt <= 1'b1;
      wr(A_CTRL, 32'h0000_000D);
      sync_pulse(3);
      wait_ready(1'b1, 1, 60);
      repeat (20) @(posedge clk);
      rdc(A_RBL, 32'h0000_0019);
      rdc(A_RAL, 32'h0000_007D);
      alt <= 1'b0;
      $display("test multipath_meter done");

      // Gain stage: gain and rounding table, adjustment frozen and cleared
      gtab = '{24'h00_1000, 24'h00_2000, 24'h00_0800, 24'h00_1000, 24'h52_0000};
      mtab = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h0};
      etab = '{32'd100, 32'd200, 32'd50, 32'd96, 32'd131071};
      ia <= 18'sd100;
      wr(A_CTRL, 32'h0000_0500);
      for (int k = 0; k < 5; k++) begin
         wr(A_GAINA, {8'h00, gtab[k]});
         wr(A_STEP, {8'h40, mtab[k], 4'h0, 16'h3277});
         repeat (3) @(posedge clk);
         cmp32({{14{agc.i[17]}}, agc.i}, etab[k]);
         chk(agc.valid === 1'b1 && agc.path_b === 1'b0, "gain stage flags wrong");
      end
      wr(A_GAINA, 32'h0000_1000);
      wr(A_STEP, 32'h4000_3277);

      // Small output: gain climbs, capped by a tiny maximum
      wr(A_AMM, 32'h8000_0001);
      wr(A_CTRL, 32'h0000_0400);
      repeat (100) @(posedge clk);
      xfer(1'b0, A_ADJA, 32'h0000_0000);
      chk($signed(rd) > 0, "adjustment did not rise");
      chk($signed(rd) < 512, "adjustment passed its maximum");
      xfer(1'b0, A_STAT, 32'h0000_0000);
      chk(rd[7:4] > 4'h8, "zero counter not above limit");

      // Masked low magnitude bits still count as zero
      wr(A_STEP, 32'h400F_3277);
      ia <= 18'sd1000;
      repeat (30) @(posedge clk);
      xfer(1'b0, A_STAT, 32'h0000_0000);
      chk(rd[7:4] > 4'h8, "masked magnitude not taken as zero");

      // Freeze through the selected sync level
      wr(A_AMM, R_AMM);
      ia <= 18'sd131071;
      wr(A_CTRL, 32'h0000_0040);
      sync_src[2] <= 1'b1;
      repeat (3) @(posedge clk);
      xfer(1'b0, A_ADJA, 32'h0000_0000);
      a0 = rd;
      repeat (30) @(posedge clk);
      rdc(A_ADJA, a0);
      sync_src[2] <= 1'b0;
      repeat (30) @(posedge clk);
      xfer(1'b0, A_ADJA, 32'h0000_0000);
      a1 = rd;
      chk($signed(a1) < $signed(a0), "gain did not fall on large output");
      $display("test gain_stage done");
      print_verdict();
   end

   // Overall bound on the run
   initial begin
      #(40 * 60000);
      miss("run time ran out");
      print_verdict();
   end
endmodule
